// file: hdl/ccis_top.sv
`timescale 1ns/10ps
module ccis_top
   import ccis_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic [15:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_wdata,
   output logic [7:0] o_sfr_rdata,
   input wire logic i_tx_ctrl_rd,
   input wire logic i_rx_ctrl_rd,
   input wire ccis_evt_t i_int_evt,
   input wire ccis_evt_t i_ext_evt,
   input wire logic i_card_detect_input,
   input wire logic i_int_card_line,
   input wire logic i_ext_card_line,
   input wire ccis_drive_t i_uart_drive,
   input wire ccis_drive_t i_int_ctrl_drive,
   input wire ccis_drive_t i_ext_ctrl_drive,
   output ccis_drive_t o_int_drive,
   output ccis_drive_t o_ext_drive,
   output logic o_route_int,
   output logic o_route_ext,
   output logic o_bypass,
   output logic o_card_irq
);

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   // Internal slot owns the UART for choice 1X
   function automatic logic choice_int(input logic [1:0] c);
      choice_int = c[1];
   endfunction

   // External companion owns the UART for choice 01 only
   function automatic logic choice_ext(input logic [1:0] c);
      choice_ext = (c == CHOICE_EXT);
   endfunction

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   ccis_state_t q;         // Registered state
   ccis_state_t d;         // Next state
   ccis_evt_t evt;         // Events of the chosen interface
   logic [1:0] choice;     // Current interface choice
   logic is_int;           // Internal slot chosen
   logic is_ext;           // External companion chosen
   logic any_if;           // Some interface chosen
   logic bypass;           // UART bypassed
   logic rd_cause;         // Cause register read this cycle
   logic [7:0] set_vec;    // Cause bits set this cycle
   logic [7:0] clr_vec;    // Cause bits cleared this cycle
   logic line_now;         // Synchronised line of chosen interface
   logic line_fall;        // Falling edge on that line
   logic card_edge;        // Card detect changed level
   logic [3:0] flag_now;   // Level flags watched for rising edges
   logic [3:0] flag_rise;  // Rising edges of those flags

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      d = q;
      choice = q.sel[SEL_CHOICE_HI:SEL_CHOICE_LO];
      is_int = choice_int(choice);
      is_ext = choice_ext(choice);
      any_if = (choice != CHOICE_NONE);
      bypass = q.sel[SEL_BYPASS];
      rd_cause = i_sfr_rd && (i_sfr_addr == ADDR_CAUSE);

      // Only the chosen interface feeds the cause bits
      if (is_int) begin
         evt = i_int_evt;
      end else if (is_ext) begin
         evt = i_ext_evt;
      end else begin
         evt = '0;
      end

      // Two-flop synchronisers for every pin
      d.cd_s1 = i_card_detect_input;
      d.cd_s2 = q.cd_s1;
      d.cd_prev = q.cd_s2;
      d.il_s1 = i_int_card_line;
      d.il_s2 = q.il_s1;
      d.el_s1 = i_ext_card_line;
      d.el_s2 = q.el_s1;

      // Edge detection works only from the second flop onward
      line_now = is_int ? q.il_s2 : q.el_s2;
      d.line_prev = line_now;
      line_fall = q.line_prev && !line_now;
      // Detect path has no card clock gating; the clock enable still freezes it
      card_edge = is_int && (q.cd_s2 != q.cd_prev);
      flag_now = {evt.tx_empty_flag, evt.tx_full_flag,
                  evt.break_seen_flag || evt.tx_underrun_flag,
                  evt.rx_overrun_flag || evt.rx_parity_err};
      d.flag_prev = flag_now;
      // Flags are levels; edges keep a held flag from re-setting
      flag_rise = flag_now & ~q.flag_prev;

      // Set sources
      set_vec = 8'h00;
      // Async timeouts, or bit-count end in sync mode
      set_vec[CB_TIMEOUT] = evt.sync_mode ? evt.bit_count_end
                                          : evt.timeout;
      set_vec[CB_CARD] = card_edge || evt.fault;
      set_vec[CB_SUPPLY] = evt.supply_seq_timer;
      set_vec[CB_RXAV] = bypass && any_if && line_fall;
      set_vec[CB_TXLVL] = flag_rise[3] || flag_rise[2];
      // A break at the end of a character-mode byte cancels done
      set_vec[CB_TXDONE] = evt.byte_sent &&
         !(evt.t0_mode && evt.break_det_en && evt.break_end);
      set_vec[CB_TXFLT] = flag_rise[1];
      set_vec[CB_RXFLT] = flag_rise[0];

      // Clear sources
      clr_vec = 8'h00;
      clr_vec[CB_TIMEOUT] = rd_cause;
      clr_vec[CB_CARD] = rd_cause;
      clr_vec[CB_SUPPLY] = rd_cause;
      clr_vec[CB_TXDONE] = rd_cause;
      clr_vec[CB_TXLVL] = i_tx_ctrl_rd;
      clr_vec[CB_TXFLT] = i_tx_ctrl_rd;
      clr_vec[CB_RXFLT] = i_rx_ctrl_rd;
      // Bypass has no FIFO to drain, so a cause read clears it
      clr_vec[CB_RXAV] = bypass && rd_cause;

      // Sticky bits; a set in the clearing cycle wins
      // Enable bits never gate this update
      d.cause = (q.cause & ~clr_vec) | set_vec;
      // Outside bypass the bit mirrors the FIFO level
      if (!bypass) begin
         d.cause[CB_RXAV] = evt.rx_not_empty;
      end

      // Register writes
      if (i_sfr_wr) begin
         case (i_sfr_addr)
            // Steering only; supply control alone starts activation
            ADDR_SEL: d.sel = i_sfr_wdata & SEL_WMASK;
            ADDR_EN: d.en = i_sfr_wdata;
            default: ; // Cause bits are not writable
         endcase
      end

      // Read data, held until the next read
      if (i_sfr_rd) begin
         case (i_sfr_addr)
            ADDR_SEL: d.rdata = q.sel;
            ADDR_CAUSE: d.rdata = q.cause;
            ADDR_EN: d.rdata = q.en;
            default: d.rdata = 8'h00; // Unmapped reads as zero
         endcase
      end

      // Enable bit n passes cause bit n
      d.irq = |(q.cause & q.en);

      // UART routing flags
      d.route_int = is_int;
      d.route_ext = is_ext;

      // Line drive; an unchosen interface is released
      d.int_drive = '{data: 1'h1, oe_n: 1'h1};
      d.ext_drive = '{data: 1'h1, oe_n: 1'h1};
      if (is_int) begin
         d.int_drive = bypass ? i_int_ctrl_drive : i_uart_drive;
      end
      if (is_ext) begin
         d.ext_drive = bypass ? i_ext_ctrl_drive : i_uart_drive;
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   // The clock enable freezes every flop, synchronisers included
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q <= '0;
         q.sel <= RST_SEL;
         q.cause <= RST_CAUSE;
         q.en <= RST_EN;
         q.cd_s1 <= 1'h0;
         q.int_drive <= '{data: 1'h1, oe_n: 1'h1};
         q.ext_drive <= '{data: 1'h1, oe_n: 1'h1};
      end else if (i_ce) begin
         q <= d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign o_sfr_rdata = q.rdata;
   assign o_card_irq = q.irq;
   assign o_route_int = q.route_int;
   assign o_route_ext = q.route_ext;
   assign o_bypass = q.sel[SEL_BYPASS];
   assign o_int_drive = q.int_drive;
   assign o_ext_drive = q.ext_drive;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Pin change that stays in view of the internal slot
   sequence s_detect_step;
      $changed(i_card_detect_input) && q.sel[SEL_CHOICE_HI];
   endsequence

   // Clock running, slot still chosen and no read in between
   sequence s_detect_quiet;
      (i_ce && !rd_cause && q.sel[SEL_CHOICE_HI])[*4];
   endsequence

   a_card_change_set: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      s_detect_step ##0 s_detect_quiet |=> q.cause[CB_CARD])
      else $error("Card detect change did not set card cause");

   a_route_follows: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce |=> (o_route_int == $past(q.sel[SEL_CHOICE_HI]))
         && (o_route_ext == ($past(q.sel[3:2]) == CHOICE_EXT)))
      else $error("UART routing does not match select field");

   a_none_quiet: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && (q.sel[3:2] == CHOICE_NONE) |=>
         (q.cause & ~$past(q.cause)) == 8'h00)
      else $error("Cause bit set with no interface chosen");

   a_read_clears: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && rd_cause && !set_vec[CB_TIMEOUT] && !set_vec[CB_TXDONE]
         |=> !q.cause[CB_TIMEOUT] && !q.cause[CB_TXDONE])
      else $error("Cause read left timeout or done set");

   a_set_wins: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && rd_cause && set_vec[CB_TIMEOUT] |=> q.cause[CB_TIMEOUT])
      else $error("Timeout event lost against read clear");

   a_rx_level: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && !q.sel[SEL_BYPASS] |=>
         q.cause[CB_RXAV] == $past(evt.rx_not_empty))
      else $error("Rx available does not track FIFO level");

   a_bypass_edge: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && q.sel[SEL_BYPASS] && (q.sel[3:2] != CHOICE_NONE)
         && q.line_prev && !line_now |=> q.cause[CB_RXAV])
      else $error("Bypass falling edge did not raise rx available");

   a_txlvl_clear: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && i_tx_ctrl_rd && !set_vec[CB_TXLVL] |=> !q.cause[CB_TXLVL])
      else $error("Tx control read left tx level set");

   a_done_break: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && evt.byte_sent && evt.t0_mode && evt.break_det_en
         && evt.break_end && !q.cause[CB_TXDONE] |=> !q.cause[CB_TXDONE])
      else $error("Tx done set on byte ended by break");

   a_rxflt_clear: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && i_rx_ctrl_rd && !set_vec[CB_RXFLT] |=> !q.cause[CB_RXFLT])
      else $error("Rx control read left rx fault set");

   a_irq_or: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce |=> o_card_irq == $past(|(q.cause & q.en)))
      else $error("Interrupt is not OR of enabled causes");

   a_masked_quiet: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      (i_ce && q.en == 8'h00)[*2] |-> !o_card_irq)
      else $error("Interrupt raised with all causes masked");

   a_bypass_drive: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && q.sel[SEL_BYPASS] && q.sel[SEL_CHOICE_HI] |=>
         o_int_drive == $past(i_int_ctrl_drive))
      else $error("Bypass line not driven from line control");

   // Supply timer expiry latches its cause bit
   a_supply_set: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && evt.supply_seq_timer |=> q.cause[CB_SUPPLY])
      else $error("Supply timer expiry did not set its cause");

   // Bit-count end stands in for timeouts in sync mode
   a_count_end: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && evt.sync_mode && evt.bit_count_end
         |=> q.cause[CB_TIMEOUT])
      else $error("Bit-count end did not set timeout cause");

   // A byte that no break ended always counts as sent
   a_done_set: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && evt.byte_sent && !evt.break_end |=> q.cause[CB_TXDONE])
      else $error("Sent byte did not set tx done");

   // Tx control read drops the tx fault bit
   a_txflt_clear: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && i_tx_ctrl_rd && !set_vec[CB_TXFLT] |=> !q.cause[CB_TXFLT])
      else $error("Tx control read left tx fault set");

   // A set cause shows in status whatever the enables hold
   a_status_kept: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && (set_vec != 8'h00) |=>
         (q.cause & $past(set_vec)) == $past(set_vec))
      else $error("Set cause bit missing from status");

   // Selector write keeps only the defined bits
   a_sel_write: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && i_sfr_wr && (i_sfr_addr == ADDR_SEL) |=>
         q.sel == ($past(i_sfr_wdata) & SEL_WMASK))
      else $error("Selector write stored wrong bits");

   // Enable register reads back what it holds
   a_en_read: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && i_sfr_rd && (i_sfr_addr == ADDR_EN) |=>
         o_sfr_rdata == $past(q.en))
      else $error("Enable register read back wrong value");

   // External companion in UART mode gets the UART drive
   a_ext_drive: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_ce && !q.sel[SEL_BYPASS] && (q.sel[3:2] == CHOICE_EXT) |=>
         o_ext_drive == $past(i_uart_drive))
      else $error("External line not driven by the UART");

   // Empty flag low, then high, on the chosen interface
   sequence s_empty_rise;
      (i_ce && !evt.tx_empty_flag) ##1 (i_ce && evt.tx_empty_flag);
   endsequence

   a_txlvl_set: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      s_empty_rise |=> q.cause[CB_TXLVL])
      else $error("Rising tx empty flag did not set tx level");

endmodule

// file: hdl/ccis_pkg.sv
// Behaviour
// - Select field routes UART: none, external, internal
// - Select write never starts card activation
// - Bypass bit drives line from line control
// - Cause read clears timeout, event, supply, done
// - Causes follow the selected interface only
// - Timeout cause on ATR or wait timeout
// - Sync mode: timeout cause at bit-count end
// - Card change cause on detect edge or fault
// - Card change works with card clock stopped
// - Supply timer expiry sets cause, read clears
// - Rx available follows FIFO not-empty level
// - Bypass: rx available on line falling edge
// - Tx level cause on flag set, tx-read clears
// - Tx done per byte, not T0 break end
// - Tx fault on break or underrun, tx-read clears
// - Rx fault on overrun or parity, rx-read clears
// - Enable bit one lets its cause interrupt
// - Masked cause still sets its status bit
// - Enable bits align with cause bit positions
package ccis_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [15:0] ADDR_SEL = 16'hFE00;
   localparam logic [15:0] ADDR_CAUSE = 16'hFE01;
   localparam logic [15:0] ADDR_EN = 16'hFE02;
   localparam logic [7:0] RST_SEL = 8'h00;
   localparam logic [7:0] RST_CAUSE = 8'h00;
   localparam logic [7:0] RST_EN = 8'h00;
   localparam logic [7:0] SEL_WMASK = 8'h0E; // Only bits 3..1 exist

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int SEL_CHOICE_HI = 3;
   localparam int SEL_CHOICE_LO = 2;
   localparam int SEL_BYPASS = 1;
   localparam int CB_TIMEOUT = 7;
   localparam int CB_CARD = 6;
   localparam int CB_SUPPLY = 5;
   localparam int CB_RXAV = 4;
   localparam int CB_TXLVL = 3;
   localparam int CB_TXDONE = 2;
   localparam int CB_TXFLT = 1;
   localparam int CB_RXFLT = 0;
   localparam logic [1:0] CHOICE_NONE = 2'h0;
   localparam logic [1:0] CHOICE_EXT = 2'h1;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   // Event and flag bundle from one card interface
   typedef struct packed {
      logic sync_mode;        // Synchronous card mode
      logic timeout;          // ATR or wait timeout pulse
      logic bit_count_end;    // Bit-length counter at terminal value
      logic fault;            // Interface fault pulse
      logic supply_seq_timer; // Supply timer expiry pulse
      logic rx_not_empty;     // Receive FIFO holds data (level)
      logic tx_empty_flag;    // Level
      logic tx_full_flag;     // Level
      logic byte_sent;        // Byte or checksum byte sent pulse
      logic t0_mode;          // Character protocol active
      logic break_det_en;     // Break detection enabled
      logic break_end;        // Break ended the byte just sent
      logic break_seen_flag;  // Level
      logic tx_underrun_flag; // Level
      logic rx_overrun_flag;  // Level
      logic rx_parity_err;    // Level
   } ccis_evt_t;

   // One card data line drive; oe_n low means driven
   typedef struct packed {
      logic data;
      logic oe_n;
   } ccis_drive_t;

   // All state of the top module
   typedef struct packed {
      logic [7:0] sel;
      logic [7:0] cause;
      logic [7:0] en;
      logic [7:0] rdata;
      logic irq;
      logic cd_s1;
      logic cd_s2;
      logic cd_prev;
      logic il_s1;
      logic il_s2;
      logic el_s1;
      logic el_s2;
      logic line_prev;
      logic [3:0] flag_prev; // Empty, full, tx fault, rx fault
      ccis_drive_t int_drive;
      ccis_drive_t ext_drive;
      logic route_int;
      logic route_ext;
   } ccis_state_t;

endpackage

// file: verification/ccis_card_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Card side model: interface event logic and card pins
// ------------------------------------------------------------
module ccis_card_model
   import ccis_pkg::*;
(
   input wire logic i_clk,
   output ccis_evt_t o_int_evt,
   output ccis_evt_t o_ext_evt,
   output logic o_card_detect_input,
   output logic o_int_card_line,
   output logic o_ext_card_line
);
   // Idle: no events, no card, data lines at their pull-up level
   initial begin
      o_int_evt = '0;
      o_ext_evt = '0;
      o_card_detect_input = 1'h0;
      o_int_card_line = 1'h1;
      o_ext_card_line = 1'h1;
   end

   // Raise or drop level fields; changes land on a falling edge only
   task automatic set(input logic ext, input ccis_evt_t m, input logic v);
      @(negedge i_clk);
      if (ext)
         o_ext_evt = v ? (o_ext_evt | m) : (o_ext_evt & ~m);
      else
         o_int_evt = v ? (o_int_evt | m) : (o_int_evt & ~m);
   endtask

   // Event pulse lasting exactly one system clock
   task automatic pulse(input logic ext, input ccis_evt_t m);
      set(ext, m, 1'h1);
      set(ext, m, 1'h0);
   endtask

   // Asynchronous pins; the design synchronises them itself
   task automatic pins(input logic cd, input logic il, input logic el);
      @(negedge i_clk);
      o_card_detect_input = cd;
      o_int_card_line = il;
      o_ext_card_line = el;
   endtask
endmodule

// file: verification/tb.sv
`timescale 1ns/10ps
module tb;
   import ccis_pkg::*;
   // ------------------------------------------------------------
   // Event bundle masks by field position; E_T0BD sets two fields
   // ------------------------------------------------------------
   localparam logic [15:0] E_SYNC = 16'h8000;
   localparam logic [15:0] E_TMO = 16'h4000;
   localparam logic [15:0] E_BCE = 16'h2000;
   localparam logic [15:0] E_FLT = 16'h1000;
   localparam logic [15:0] E_SUP = 16'h0800;
   localparam logic [15:0] E_RXNE = 16'h0400;
   localparam logic [15:0] E_TXE = 16'h0200;
   localparam logic [15:0] E_SENT = 16'h0080;
   localparam logic [15:0] E_T0BD = 16'h0060; // Char protocol, break detect
   localparam logic [15:0] E_BRKE = 16'h0010;
   localparam logic [15:0] E_BRK = 16'h0008;
   localparam logic [15:0] E_OVR = 16'h0002;
   logic i_clk = 1'h0;
   logic i_resetn = 1'h0;
   logic ce = 1'h1;
   logic [15:0] sfr_addr = 16'h0000;
   logic sfr_wr = 1'h0;
   logic sfr_rd = 1'h0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic tx_rd = 1'h0;
   logic rx_rd = 1'h0;
   ccis_evt_t int_evt;
   ccis_evt_t ext_evt;
   logic card_det;
   logic int_line;
   logic ext_line;
   ccis_drive_t uart_drv = 2'h2; // UART drives a one
   ccis_drive_t ictl_drv = 2'h3;
   ccis_drive_t ectl_drv = 2'h3;
   ccis_drive_t int_drv;
   ccis_drive_t ext_drv;
   logic route_int;
   logic route_ext;
   logic bypass;
   logic card_irq;
   int errors = 0;
   int checks_done = 0;

   // 125 MHz system clock
   always #4 i_clk = ~i_clk;

   ccis_top ccis_top_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(ce),
      .i_sfr_addr(sfr_addr), .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd),
      .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(sfr_rdata),
      .i_tx_ctrl_rd(tx_rd), .i_rx_ctrl_rd(rx_rd), .i_int_evt(int_evt),
      .i_ext_evt(ext_evt), .i_card_detect_input(card_det),
      .i_int_card_line(int_line), .i_ext_card_line(ext_line),
      .i_uart_drive(uart_drv), .i_int_ctrl_drive(ictl_drv),
      .i_ext_ctrl_drive(ectl_drv), .o_int_drive(int_drv),
      .o_ext_drive(ext_drv), .o_route_int(route_int),
      .o_route_ext(route_ext), .o_bypass(bypass), .o_card_irq(card_irq));

   ccis_card_model ccis_card_model_inst (.i_clk(i_clk), .o_int_evt(int_evt),
      .o_ext_evt(ext_evt), .o_card_detect_input(card_det),
      .o_int_card_line(int_line), .o_ext_card_line(ext_line));

   // ------------------------------------------------------------
   // Shared helpers: compare, bus cycles, event stimulus
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("BAD at %0t: saw %h, wanted %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // One-cycle strobes, raised and dropped at falling edges
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(negedge i_clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'h1;
      @(negedge i_clk);
      sfr_wr = 1'h0;
   endtask
   // Read data is registered, so it is taken one cycle after the strobe
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      @(negedge i_clk);
      sfr_addr = a;
      sfr_rd = 1'h1;
      @(negedge i_clk);
      sfr_rd = 1'h0;
      chk(sfr_rdata, exp);
   endtask
   task automatic ctl(input logic tx);
      @(negedge i_clk);
      tx_rd = tx;
      rx_rd = ~tx;
      @(negedge i_clk);
      tx_rd = 1'h0;
      rx_rd = 1'h0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   task automatic ev(input logic ext, input logic [15:0] m);
      ccis_card_model_inst.pulse(ext, m);
   endtask
   task automatic lv(input logic ext, input logic [15:0] m, input logic v);
      ccis_card_model_inst.set(ext, m, v);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      rd_chk(ADDR_SEL, 8'h00);
      rd_chk(ADDR_CAUSE, 8'h00);
      rd_chk(ADDR_EN, 8'h00);
      wr_reg(16'hFE05, 8'hFF);
      rd_chk(16'hFE05, 8'h00);
      wr_reg(ADDR_CAUSE, 8'hFF);
      rd_chk(ADDR_CAUSE, 8'h00);
      wr_reg(ADDR_SEL, 8'hFF);
      rd_chk(ADDR_SEL, 8'h0E);
      chk({5'h00, route_int, route_ext, bypass}, 8'h05);
      wr_reg(ADDR_SEL, 8'h04);
      idle(2);
      chk({6'h00, route_int, route_ext}, 8'h01);
      chk({6'h00, int_drv}, 8'h03);
      wr_reg(ADDR_SEL, 8'h00);
      idle(2);
      chk({6'h00, route_int, route_ext}, 8'h00);
      $display("registers done");
   endtask
   task automatic t_clear();
      wr_reg(ADDR_SEL, 8'h08);
      ev(0, E_TMO);
      ev(0, E_FLT);
      ev(0, E_SUP);
      ev(0, E_SENT);
      chk({7'h00, card_irq}, 8'h00);
      rd_chk(ADDR_CAUSE, 8'hE4);
      rd_chk(ADDR_CAUSE, 8'h00);
      lv(0, E_T0BD, 1'h1);
      ev(0, E_SENT | E_BRKE);
      lv(0, E_T0BD, 1'h0);
      rd_chk(ADDR_CAUSE, 8'h00);
      lv(0, E_SYNC, 1'h1);
      ev(0, E_TMO);
      rd_chk(ADDR_CAUSE, 8'h00);
      ev(0, E_BCE);
      rd_chk(ADDR_CAUSE, 8'h80);
      lv(0, E_SYNC, 1'h0);
      $display("read clear done");
   endtask
   task automatic t_select();
      wr_reg(ADDR_SEL, 8'h04);
      ev(0, E_SUP);
      rd_chk(ADDR_CAUSE, 8'h00);
      ev(1, E_SUP);
      ev(1, E_FLT);
      rd_chk(ADDR_CAUSE, 8'h60);
      wr_reg(ADDR_SEL, 8'h00);
      ev(1, E_SUP);
      ev(0, E_SUP);
      rd_chk(ADDR_CAUSE, 8'h00);
      $display("select done");
   endtask
   task automatic t_irq();
      wr_reg(ADDR_SEL, 8'h08);
      ev(0, E_TMO | E_FLT | E_SUP | E_SENT);
      // Each enable bit alone: only the set causes may interrupt
      for (int k = 0; k < 8; k++) begin
         wr_reg(ADDR_EN, 8'h01 << k);
         idle(2);
         chk({7'h00, card_irq}, (8'hE4 >> k) & 8'h01);
      end
      wr_reg(ADDR_EN, 8'h1B);
      idle(2);
      chk({7'h00, card_irq}, 8'h00);
      wr_reg(ADDR_EN, 8'hE4);
      rd_chk(ADDR_CAUSE, 8'hE4);
      idle(2);
      chk({7'h00, card_irq}, 8'h00);
      wr_reg(ADDR_EN, 8'h00);
      $display("interrupt enable done");
   endtask
   task automatic t_flags();
      lv(0, E_TXE, 1'h1);
      idle(3);
      rd_chk(ADDR_CAUSE, 8'h08);
      ctl(1);
      rd_chk(ADDR_CAUSE, 8'h00);
      lv(0, E_BRK, 1'h1);
      idle(3);
      ctl(0);
      rd_chk(ADDR_CAUSE, 8'h02);
      ctl(1);
      rd_chk(ADDR_CAUSE, 8'h00);
      lv(0, E_OVR, 1'h1);
      idle(3);
      ctl(1);
      rd_chk(ADDR_CAUSE, 8'h01);
      ctl(0);
      rd_chk(ADDR_CAUSE, 8'h00);
      lv(0, E_TXE | E_BRK | E_OVR | E_RXNE, 1'h0);
      lv(0, E_RXNE, 1'h1);
      idle(2);
      rd_chk(ADDR_CAUSE, 8'h10);
      rd_chk(ADDR_CAUSE, 8'h10);
      lv(0, E_RXNE, 1'h0);
      idle(2);
      rd_chk(ADDR_CAUSE, 8'h00);
      $display("flag causes done");
   endtask
   task automatic t_bypass();
      ictl_drv = 2'h0;
      wr_reg(ADDR_SEL, 8'h0A);
      idle(3);
      chk({4'h0, int_drv, ext_drv}, 8'h03);
      wr_reg(ADDR_SEL, 8'h08);
      idle(3);
      chk({4'h0, int_drv, ext_drv}, 8'h0B);
      wr_reg(ADDR_SEL, 8'h0A);
      wr_reg(ADDR_EN, 8'h10);
      ccis_card_model_inst.pins(1'h0, 1'h0, 1'h1);
      idle(5);
      chk({7'h00, card_irq}, 8'h01);
      // Firmware mutes the start edge until the byte is taken in
      wr_reg(ADDR_EN, 8'h00);
      idle(2);
      chk({7'h00, card_irq}, 8'h00);
      rd_chk(ADDR_CAUSE, 8'h10);
      ccis_card_model_inst.pins(1'h1, 1'h1, 1'h1);
      idle(5);
      rd_chk(ADDR_CAUSE, 8'h40);
      ccis_card_model_inst.pins(1'h0, 1'h1, 1'h1);
      idle(5);
      rd_chk(ADDR_CAUSE, 8'h40);
      ectl_drv = 2'h0;
      wr_reg(ADDR_SEL, 8'h06);
      idle(3);
      chk({4'h0, int_drv, ext_drv}, 8'h0C);
      $display("bypass done");
   endtask
   // Clock enable low ignores a write; a mid-run reset restores the selector, routing and internal drive reset values
   task automatic t_hold();
      ce = 1'h0;
      wr_reg(ADDR_EN, 8'hFF);
      ce = 1'h1;
      rd_chk(ADDR_EN, 8'h00);
      wr_reg(ADDR_SEL, 8'h0A);
      i_resetn = 1'h0;
      @(negedge i_clk);
      i_resetn = 1'h1;
      rd_chk(ADDR_SEL, 8'h00);
      chk({4'h0, route_int, route_ext, int_drv}, 8'h03);
      $display("hold and reset done");
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   // Recovery after a fault is left wholly to the firmware side
   initial begin
      repeat (5) @(negedge i_clk);
      i_resetn = 1'h1;
      t_regs();
      t_clear();
      t_select();
      t_irq();
      t_flags();
      t_bypass();
      t_hold();
      complete_run();
   end
   // Whole run needs well under two thousand cycles
   initial begin
      #100000;
      errors++;
      complete_run();
   end
endmodule
